// ===== hw/bit_branch_call_exec.sv
/*
  Execution of bit clear/set, bit test with skip, relative branches, and
  absolute subroutine call for an 8-bit core.
  Assumes the register file answers rf_rdata combinationally for rf_addr,
  and the return stack takes stack_top on the push pulse.
// Operation
// RULE1 - Bit clear zeroes one bit only
// RULE2 - Bit set raises one bit only
// RULE3 - Literal branch: target is PC+1+signed literal
// RULE4 - Literal branch takes two cycles, no flags
// RULE5 - Accumulator branch: PC+1+unsigned accumulator, two cycles
// RULE6 - Test clear skips next when bit zero
// RULE7 - Test set skips next when bit one
// RULE8 - Call pushes PC+1, loads eleven bits
// RULE9 - Call fills PC top from latch bits
// RULE10 - Discarded instruction only advances PC
*/
`timescale 1ns/1ns
`include "bbc_defs.svh"

module bit_branch_call_exec #(
  parameter int PC_W = `BBC_PC_W
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    instr_valid,
  input  wire bbc_pkg::op_t            op,
  input  wire logic [`BBC_FADDR_W-1:0] f_addr,
  input  wire logic [`BBC_BIDX_W-1:0]  bit_idx,
  input  wire logic [`BBC_LIT_W-1:0]   literal,
  input  wire logic [`BBC_DATA_W-1:0]  accumulator,
  input  wire logic [`BBC_DATA_W-1:0]  upper_address_latch,
  input  wire logic [`BBC_DATA_W-1:0]  rf_rdata,
  output logic                         ready_r,
  output logic      [PC_W-1:0]         pc_r,
  output logic      [`BBC_FADDR_W-1:0] rf_addr_r,
  output logic      [`BBC_DATA_W-1:0]  rf_wdata_r,
  output logic                         rf_we_r,
  output logic                         push_r,
  output logic      [PC_W-1:0]         stack_top_r
);

  // Refuse program counter widths that cannot hold the call target
  if (PC_W < `BBC_LIT_W + `BBC_UAL_HI - `BBC_UAL_LO + 1) begin : g_chk
    $error("PC_W too small for call target");
  end

  bbc_pkg::state_t             state_r;
  bbc_pkg::op_t                op_r;
  logic [`BBC_BIDX_W-1:0]      bidx_r;
  logic [`BBC_LIT_W-1:0]       lit_r;
  logic                        skip_pend_r;
  logic [`BBC_DATA_W-1:0]      mod_data;
  logic                        tested_bit;
  logic [PC_W-1:0]             pc_inc;
  logic [PC_W-1:0]             br_off;
  logic [PC_W-1:0]             acc_off;
  logic [PC_W-1:0]             call_tgt;
  logic                        accept;
  logic                        exec_st;

  // Sign-extend a branch literal to the program counter width
  function automatic logic [PC_W-1:0] sext_branch(input logic [`BBC_LIT_W-1:0] l);
    sext_branch = {{(PC_W-`BBC_BR_W){l[`BBC_BR_W-1]}}, l[`BBC_BR_W-1:0]};
  endfunction

  // Form the call target from literal and latch bits
  function automatic logic [PC_W-1:0] call_addr(input logic [`BBC_LIT_W-1:0] l,
                                                input logic [`BBC_DATA_W-1:0] u);
    call_addr = PC_W'({u[`BBC_UAL_HI:`BBC_UAL_LO], l});
  endfunction

  // Bit operand datapath
  bit_modify_unit u_bit (
    .data_in   (rf_rdata),
    .bit_idx   (bidx_r),
    .set_level (op_r == bbc_pkg::OP_BIT_SET),
    .data_out  (mod_data),
    .bit_level (tested_bit)
  );

  // Address arithmetic
  assign accept   = (state_r == bbc_pkg::ST_IDLE) && instr_valid;
  assign exec_st  = (state_r == bbc_pkg::ST_EXEC);
  assign pc_inc   = pc_r + PC_W'(1);
  assign br_off   = sext_branch(lit_r);                                   // RULE3
  assign acc_off  = {{(PC_W-`BBC_DATA_W){1'b0}}, accumulator};           // RULE5
  assign call_tgt = call_addr(lit_r, upper_address_latch);                // RULE9

  // Sequencer: one cycle per instruction, an extra flush for taken flow changes
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= bbc_pkg::ST_IDLE;
    end else begin
      case (state_r)
        bbc_pkg::ST_IDLE: begin
          if (instr_valid) begin
            state_r <= bbc_pkg::ST_EXEC;
          end
        end
        bbc_pkg::ST_EXEC: begin
          case (op_r)
            bbc_pkg::OP_BR_LIT, bbc_pkg::OP_BR_ACC, bbc_pkg::OP_CALL: begin
              state_r <= bbc_pkg::ST_FLUSH;                               // RULE4
            end
            default: begin
              state_r <= bbc_pkg::ST_IDLE;
            end
          endcase
        end
        bbc_pkg::ST_FLUSH: begin
          state_r <= bbc_pkg::ST_IDLE;
        end
        default: begin
          state_r <= bbc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Ready while waiting for the next instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_r <= 1'b1;
    end else if (accept) begin
      ready_r <= 1'b0;
    end else if ((exec_st && op_r inside {bbc_pkg::OP_BR_LIT, bbc_pkg::OP_BR_ACC, bbc_pkg::OP_CALL}) ||
                 (state_r == bbc_pkg::ST_IDLE)) begin
      ready_r <= 1'b0 | (state_r == bbc_pkg::ST_IDLE);
    end else begin
      ready_r <= 1'b1;
    end
  end

  // Capture the instruction; a skipped one becomes a no-operation
  always_ff @(posedge clk) begin
    if (rst) begin
      op_r      <= bbc_pkg::OP_NOP;
      bidx_r    <= '0;
      lit_r     <= '0;
      rf_addr_r <= '0;
    end else if (accept) begin
      op_r      <= skip_pend_r ? bbc_pkg::OP_NOP : op;                    // RULE10
      bidx_r    <= bit_idx;
      lit_r     <= literal;
      rf_addr_r <= f_addr;
    end
  end

  // Pending skip from a bit test, consumed by the next accepted instruction
  always_ff @(posedge clk) begin
    if (rst) begin
      skip_pend_r <= 1'b0;
    end else if (exec_st && op_r == bbc_pkg::OP_TST_CLR) begin
      skip_pend_r <= ~tested_bit;                                         // RULE6
    end else if (exec_st && op_r == bbc_pkg::OP_TST_SET) begin
      skip_pend_r <= tested_bit;                                          // RULE7
    end else if (accept) begin
      skip_pend_r <= 1'b0;
    end
  end

  // Register file write-back for the bit operations only
  always_ff @(posedge clk) begin
    if (rst) begin
      rf_we_r    <= 1'b0;
      rf_wdata_r <= '0;
    end else begin
      rf_we_r <= exec_st && (op_r inside {bbc_pkg::OP_BIT_CLR, bbc_pkg::OP_BIT_SET}); // RULE1 RULE2
      if (exec_st) begin
        rf_wdata_r <= mod_data;                                           // RULE1 RULE2
      end
    end
  end

  // Program counter update
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_r <= PC_W'(`BBC_PC_RST);
    end else if (exec_st) begin
      case (op_r)
        bbc_pkg::OP_BR_LIT:  pc_r <= pc_inc + br_off;                     // RULE3
        bbc_pkg::OP_BR_ACC:  pc_r <= pc_inc + acc_off;                    // RULE5
        bbc_pkg::OP_CALL:    pc_r <= call_tgt;                            // RULE8 RULE9
        default:             pc_r <= pc_inc;                              // RULE10
      endcase
    end
  end

  // Return stack push on a call
  always_ff @(posedge clk) begin
    if (rst) begin
      push_r      <= 1'b0;
      stack_top_r <= '0;
    end else begin
      push_r <= exec_st && op_r == bbc_pkg::OP_CALL;                      // RULE8
      if (exec_st && op_r == bbc_pkg::OP_CALL) begin
        stack_top_r <= pc_inc;                                            // RULE8
      end
    end
  end

  // Checks
  sequence flush_then_idle_s;
    state_r == bbc_pkg::ST_FLUSH ##1 state_r == bbc_pkg::ST_IDLE;
  endsequence

  sequence exec_op_s(bbc_pkg::op_t o);
    exec_st && op_r == o;
  endsequence

  bit_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    exec_op_s(bbc_pkg::OP_BIT_CLR) |=> rf_we_r && !rf_wdata_r[$past(bidx_r)] &&
      ((rf_wdata_r ^ $past(rf_rdata)) & ~(8'h01 << $past(bidx_r))) == 8'h00)
    else $error("bit clear result wrong");

  bit_set_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    exec_op_s(bbc_pkg::OP_BIT_SET) |=> rf_we_r && rf_wdata_r[$past(bidx_r)] &&
      ((rf_wdata_r ^ $past(rf_rdata)) & ~(8'h01 << $past(bidx_r))) == 8'h00)
    else $error("bit set result wrong");

  branch_target_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    exec_op_s(bbc_pkg::OP_BR_LIT) |=> pc_r == $past(pc_r) + PC_W'(1) + sext_branch($past(lit_r)))
    else $error("literal branch target wrong");

  branch_two_cycle_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    exec_op_s(bbc_pkg::OP_BR_LIT) |=> flush_then_idle_s and (!rf_we_r && !push_r)[*2])
    else $error("literal branch not two cycles");

  acc_branch_a: assert property (@(posedge clk) disable iff (rst) // RULE5
    exec_op_s(bbc_pkg::OP_BR_ACC) |=> pc_r == $past(pc_r) + PC_W'(1) +
      {{(PC_W-8){1'b0}}, $past(accumulator)} ##0 flush_then_idle_s)
    else $error("accumulator branch wrong");

  skip_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE6
    exec_op_s(bbc_pkg::OP_TST_CLR) |=> skip_pend_r == !$past(rf_rdata[bidx_r]))
    else $error("skip if clear wrong");

  skip_set_a: assert property (@(posedge clk) disable iff (rst) // RULE7
    exec_op_s(bbc_pkg::OP_TST_SET) |=> skip_pend_r == $past(rf_rdata[bidx_r]))
    else $error("skip if set wrong");

  call_push_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    exec_op_s(bbc_pkg::OP_CALL) |=> push_r && stack_top_r == $past(pc_r) + PC_W'(1) &&
      pc_r[`BBC_LIT_W-1:0] == $past(lit_r) ##0 flush_then_idle_s)
    else $error("call push or target wrong");

  call_upper_a: assert property (@(posedge clk) disable iff (rst) // RULE9
    exec_op_s(bbc_pkg::OP_CALL) |=>
      pc_r[`BBC_LIT_W+3:`BBC_LIT_W] == $past(upper_address_latch[`BBC_UAL_HI:`BBC_UAL_LO]))
    else $error("call upper bits wrong");

  discard_a: assert property (@(posedge clk) disable iff (rst) // RULE10
    accept && skip_pend_r |=> op_r == bbc_pkg::OP_NOP ##1
      (!rf_we_r && !push_r && pc_r == $past(pc_r) + PC_W'(1) && state_r == bbc_pkg::ST_IDLE))
    else $error("discarded instruction had effect");

endmodule

// ===== inc/bbc_defs.svh
/*
  Constants for the bit, branch and call execution block: field widths,
  field positions and reset values.
  Assumes inclusion by bare name from files that need these values.
*/
`ifndef BBC_DEFS_SVH
`define BBC_DEFS_SVH

`define BBC_PC_W       15
`define BBC_DATA_W     8
`define BBC_FADDR_W    7
`define BBC_BIDX_W     3
`define BBC_LIT_W      11
`define BBC_BR_W       9
`define BBC_UAL_LO     3
`define BBC_UAL_HI     6
`define BBC_PC_RST     15'h0000

`endif

// ===== inc/bbc_pkg.sv
/*
  Types for the bit, branch and call execution block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bbc_pkg;

  // Operation codes presented by the fetch stage
  typedef enum logic [2:0] {
    OP_NOP     = 3'h0,
    OP_BIT_CLR = 3'h1,
    OP_BIT_SET = 3'h2,
    OP_TST_CLR = 3'h3,
    OP_TST_SET = 3'h4,
    OP_BR_LIT  = 3'h5,
    OP_BR_ACC  = 3'h6,
    OP_CALL    = 3'h7
  } op_t;

  // Execution sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_FLUSH = 3'b100
  } state_t;

endpackage

// ===== hw/bit_modify_unit.sv
/*
  Bit modify and test unit: forces one bit of a data byte to a level and
  reports the level of that bit before the change.
  Assumes a data byte and a bit index that are stable during the cycle.
*/
`timescale 1ns/1ns
`include "bbc_defs.svh"

module bit_modify_unit (
  input  wire logic [`BBC_DATA_W-1:0] data_in,
  input  wire logic [`BBC_BIDX_W-1:0] bit_idx,
  input  wire logic                   set_level,
  output logic      [`BBC_DATA_W-1:0] data_out,
  output logic                        bit_level
);

  // Only the selected position takes the forced level
  for (genvar i = 0; i < `BBC_DATA_W; i++) begin : g_bit
    assign data_out[i] = (int'(bit_idx) == i) ? set_level : data_in[i];
  end

  // Level of the tested bit
  assign bit_level = data_in[bit_idx];

endmodule

// ===== testbench/bit_branch_call_exec_bench.sv
/*
  Self-checking bench for bit_branch_call_exec: edge cases and random
  instructions; the driver queues notes, a monitor compares them.
  Assumes bbc_pkg and bbc_defs.svh are compiled before this file.
*/
`timescale 1ns/1ns
`include "bbc_defs.svh"

module bit_branch_call_exec_bench;
  typedef struct {
    logic [14:0] pc;
    logic        we;
    logic [6:0]  a;
    logic [7:0]  d;
    logic        push;
    logic [14:0] top;
    int          cyc;
  } note_t;

  logic           clk = 1'b0;
  logic           rst;
  logic           instr_valid;
  bbc_pkg::op_t   op;
  logic [6:0]     f_addr;
  logic [2:0]     bit_idx;
  logic [10:0]    literal;
  logic [7:0]     accumulator;
  logic [7:0]     upper_address_latch;
  logic [7:0]     rf_rdata;
  logic           ready_r;
  logic [14:0]    pc_r;
  logic [6:0]     rf_addr_r;
  logic [7:0]     rf_wdata_r;
  logic           rf_we_r;
  logic           push_r;
  logic [14:0]    stack_top_r;
  note_t          notes[$];
  note_t          got;
  logic [7:0]     mem[128];
  logic [7:0]     ref_mem[128];
  logic [14:0]    ref_pc;
  logic           skip_pend;
  logic           seen_we;
  logic           seen_push;
  logic           prev_ready;
  logic [6:0]     seen_a;
  logic [7:0]     seen_d;
  logic [14:0]    seen_top;
  logic [31:0]    r;
  integer         seed = 32'h4945;
  int             failures;
  int             n_checks;
  int             cycles;
  int             low_cnt;

  bit_branch_call_exec dut_u (
    .clk(clk), .rst(rst), .instr_valid(instr_valid), .op(op), .f_addr(f_addr),
    .bit_idx(bit_idx), .literal(literal), .accumulator(accumulator),
    .upper_address_latch(upper_address_latch), .rf_rdata(rf_rdata), .ready_r(ready_r),
    .pc_r(pc_r), .rf_addr_r(rf_addr_r), .rf_wdata_r(rf_wdata_r), .rf_we_r(rf_we_r),
    .push_r(push_r), .stack_top_r(stack_top_r)
  );

  // Register file answers combinationally, takes writes on the edge
  assign rf_rdata = mem[rf_addr_r];
  always @(posedge clk) begin
    if (rf_we_r === 1'b1) mem[rf_addr_r] <= rf_wdata_r;
  end

  // Clock
  always #4 clk = ~clk;

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task test_done;
    $display("checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Queue the expected outcome, offer the instruction, wait for ready
  task issue(input bbc_pkg::op_t o, input logic [6:0] fa, input logic [2:0] bi,
             input logic [10:0] lit, input logic [7:0] acc, input logic [7:0] ual);
    note_t      n;
    logic [7:0] v;
    int         k;
    n = '{pc: ref_pc + 15'h1, we: 1'b0, a: fa, d: 8'h00, push: 1'b0, top: 15'h0, cyc: 1};
    v = ref_mem[fa];
    if (skip_pend) skip_pend = 1'b0;
    else begin
      case (o)
        bbc_pkg::OP_BIT_CLR, bbc_pkg::OP_BIT_SET: begin
          v[bi] = (o == bbc_pkg::OP_BIT_SET);
          n.we = 1'b1;
          n.d = v;
          ref_mem[fa] = v;
        end
        bbc_pkg::OP_TST_CLR: skip_pend = ~v[bi];
        bbc_pkg::OP_TST_SET: skip_pend = v[bi];
        bbc_pkg::OP_BR_LIT: begin
          n.pc = ref_pc + 15'h1 + {{6{lit[8]}}, lit[8:0]};
          n.cyc = 2;
        end
        bbc_pkg::OP_BR_ACC: begin
          n.pc = ref_pc + 15'h1 + {7'h00, acc};
          n.cyc = 2;
        end
        bbc_pkg::OP_CALL: begin
          n.pc = {ual[6:3], lit};
          n.push = 1'b1;
          n.top = ref_pc + 15'h1;
          n.cyc = 2;
        end
        default: ;
      endcase
    end
    ref_pc = n.pc;
    notes.push_back(n);
    instr_valid = 1'b1;
    op = o;
    f_addr = fa;
    bit_idx = bi;
    literal = lit;
    accumulator = acc;
    upper_address_latch = ual;
    @(posedge clk);
    #1 instr_valid = 1'b0;
    for (k = 0; k < 10 && ready_r !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Collect pulses; on each return of ready compare with the oldest note
  always @(negedge clk) begin
    if (rst === 1'b0) begin
      if (rf_we_r === 1'b1) begin
        seen_we = 1'b1;
        seen_a = rf_addr_r;
        seen_d = rf_wdata_r;
      end
      if (push_r === 1'b1) begin
        seen_push = 1'b1;
        seen_top = stack_top_r;
      end
      if (ready_r !== 1'b1) low_cnt++;
      else if (prev_ready === 1'b0 && notes.size() > 0) begin
        got = notes.pop_front();
        check("pc", {17'h0, pc_r}, {17'h0, got.pc});
        check("write", {31'h0, seen_we}, {31'h0, got.we});
        if (got.we) check("wdata", {17'h0, seen_a, seen_d}, {17'h0, got.a, got.d});
        check("push", {31'h0, seen_push}, {31'h0, got.push});
        if (got.push) check("top", {17'h0, seen_top}, {17'h0, got.top});
        check("busy", low_cnt, got.cyc);
        seen_we = 1'b0;
        seen_push = 1'b0;
        low_cnt = 0;
      end
      prev_ready = ready_r;
    end
  end

  // Main sequence: edge cases, then random instructions
  initial begin
    {instr_valid, f_addr, bit_idx, literal, accumulator, upper_address_latch} = '0;
    op = bbc_pkg::OP_NOP;
    {skip_pend, seen_we, seen_push, low_cnt, ref_pc} = '0;
    prev_ready = 1'b1;
    for (int i = 0; i < 128; i++) begin
      r = $random(seed);
      mem[i] = r[7:0];
      ref_mem[i] = r[7:0];
    end
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    issue(bbc_pkg::OP_CALL, 7'h00, 3'h0, 11'h7ff, 8'h00, 8'hb8);
    issue(bbc_pkg::OP_BR_LIT, 7'h00, 3'h0, 11'h100, 8'h00, 8'h00);
    issue(bbc_pkg::OP_BR_LIT, 7'h00, 3'h0, 11'h0ff, 8'h00, 8'h00);
    issue(bbc_pkg::OP_BR_ACC, 7'h00, 3'h0, 11'h000, 8'hff, 8'h00);
    issue(bbc_pkg::OP_BIT_CLR, 7'h7f, 3'h7, 11'h000, 8'h00, 8'h00);
    issue(bbc_pkg::OP_TST_CLR, 7'h7f, 3'h7, 11'h000, 8'h00, 8'h00);
    issue(bbc_pkg::OP_BIT_SET, 7'h7f, 3'h7, 11'h000, 8'h00, 8'h00);
    issue(bbc_pkg::OP_TST_SET, 7'h7f, 3'h7, 11'h000, 8'h00, 8'h00);
    issue(bbc_pkg::OP_BIT_SET, 7'h00, 3'h0, 11'h000, 8'h00, 8'h00);
    issue(bbc_pkg::OP_TST_SET, 7'h00, 3'h0, 11'h000, 8'h00, 8'h00);
    issue(bbc_pkg::OP_CALL, 7'h00, 3'h0, 11'h123, 8'h00, 8'hff);
    for (int i = 0; i < 200; i++) begin
      r = $random(seed);
      issue(bbc_pkg::op_t'(r[2:0]), r[9:3], r[12:10], r[23:13], r[31:24], r[20:13]);
    end
    repeat (4) @(posedge clk);
    check("pending", notes.size(), 0);
    test_done();
  end
endmodule
